/* File: design/ildd_map.svh */
// Address constants for the logical device I/O decoder
// How it works
// - Relocatable bases come from configuration inputs.
// - Every register access moves one byte.
// - Programmed I/O and DMA cycles both accepted.
// - Zero wait except parallel port and clock cycles.
// - All sixteen address bits are compared.
// - Parallel base range, enhanced needs 8-byte alignment.
// - Parallel offsets 0-2 and 400h-402h decoded.
// - Clock index 70h/74h, data 71h/76h.
// - Keyboard data 60h, command/status 64h.
`ifndef ILDD_MAP_SVH
`define ILDD_MAP_SVH

// Fixed windows
`define ILDD_RTC_ADDR0 16'h0070
`define ILDD_RTC_ADDR1 16'h0074
`define ILDD_RTC_DATA0 16'h0071
`define ILDD_RTC_DATA1 16'h0076
`define ILDD_KBD_DATA 16'h0060
`define ILDD_KBD_CMD 16'h0064

// Relocation limits and spans
`define ILDD_RELOC_MIN 16'h0100
`define ILDD_PAR_MAX 16'h0ffc
`define ILDD_SER_MAX 16'h0ff8
`define ILDD_PAR_STD_SPAN 16'h0003
`define ILDD_PAR_ENH_SPAN 16'h0008
`define ILDD_PAR_EXT_FIRST 16'h0400
`define ILDD_PAR_EXT_LAST 16'h0402
`define ILDD_FDC_HOLE 3'h6

// Register index codes on reg_idx_o
`define ILDD_IDX_PAR_EXT 2'h2
`define ILDD_IDX_FDC_FIFO 4'h5
`define ILDD_IDX_PAR_FIFO 4'h8
`define ILDD_IDX_RTC_ADDR 4'h0
`define ILDD_IDX_RTC_DATA 4'h1
`define ILDD_IDX_KBD_DATA 4'h0
`define ILDD_IDX_KBD_CMD 4'h1
`define ILDD_IDX_NONE 4'h0

`endif

/* File: design/ildd_pkg.sv */
// Types shared by the logical device I/O decoder
package ildd_pkg;
  typedef enum logic [2:0] {
    ildd_dev_none = 3'b000,
    ildd_dev_floppy = 3'b001,
    ildd_dev_parport = 3'b010,
    ildd_dev_serial1 = 3'b011,
    ildd_dev_serial2 = 3'b100,
    ildd_dev_rtc = 3'b101,
    ildd_dev_kbd = 3'b110
  } ildd_dev_t;
endpackage

/* File: design/ildd_dec_if.sv */
// Carrier between the decoder core and its address matcher
`timescale 1ns/100ps
`default_nettype none
interface ildd_dec_if;
  import ildd_pkg::*;
  logic [15:0] addr;
  logic [15:0] fdc_base;
  logic [15:0] par_base;
  logic [15:0] ser1_base;
  logic [15:0] ser2_base;
  logic [3:0] win_en;
  logic par_enh_mode;
  ildd_dev_t dev;
  logic [3:0] idx;
  logic enh_ok;
  modport ctl (output addr, fdc_base, par_base, ser1_base, ser2_base, win_en, par_enh_mode,
               input dev, idx, enh_ok);
  modport dec (input addr, fdc_base, par_base, ser1_base, ser2_base, win_en, par_enh_mode,
               output dev, idx, enh_ok);
endinterface
`default_nettype wire

/* File: design/ildd_addr_decode.sv */
// Combinational address matcher for all logical device windows
`timescale 1ns/100ps
`default_nettype none
`include "ildd_map.svh"
module ildd_addr_decode (
  // Address and configuration in, selection out
  ildd_dec_if.dec dif
);
  import ildd_pkg::*;

  logic [15:0] par_al;
  logic [15:0] par_diff;
  logic par_ok;
  logic ser1_ok;
  logic ser2_ok;
  logic fdc_hit;
  logic par_std_hit;
  logic par_ext_hit;
  logic ser1_hit;
  logic ser2_hit;

  // Window base checks; a base outside its range disables the window
  assign par_al = {dif.par_base[15:2], 2'b00};
  assign par_ok = dif.win_en[1] && par_al >= `ILDD_RELOC_MIN && par_al <= `ILDD_PAR_MAX;
  assign ser1_ok = dif.win_en[2] && {dif.ser1_base[15:3], 3'b000} >= `ILDD_RELOC_MIN
                   && {dif.ser1_base[15:3], 3'b000} <= `ILDD_SER_MAX;
  assign ser2_ok = dif.win_en[3] && {dif.ser2_base[15:3], 3'b000} >= `ILDD_RELOC_MIN
                   && {dif.ser2_base[15:3], 3'b000} <= `ILDD_SER_MAX;
  // Enhanced mode only when the parallel base sits on an 8-byte boundary
  assign dif.enh_ok = par_ok && (dif.par_base[2] == 1'b0);

  // Full-width matches; the subtraction keeps all sixteen bits in play
  assign par_diff = dif.addr - par_al;
  assign fdc_hit = dif.win_en[0] && dif.addr[15:3] == dif.fdc_base[15:3]
                   && dif.addr[2:0] != `ILDD_FDC_HOLE;
  assign par_std_hit = par_ok && (par_diff < `ILDD_PAR_STD_SPAN
                       || (dif.par_enh_mode && dif.enh_ok && par_diff < `ILDD_PAR_ENH_SPAN));
  assign par_ext_hit = par_ok && par_diff >= `ILDD_PAR_EXT_FIRST
                       && par_diff <= `ILDD_PAR_EXT_LAST;
  assign ser1_hit = ser1_ok && dif.addr[15:3] == dif.ser1_base[15:3];
  assign ser2_hit = ser2_ok && dif.addr[15:3] == dif.ser2_base[15:3];

  // Priority select; overlapping windows resolve to the earlier device
  always_comb begin
    dif.dev = ildd_dev_none;
    dif.idx = `ILDD_IDX_NONE;
    if (fdc_hit) begin
      dif.dev = ildd_dev_floppy;
      dif.idx = {1'b0, dif.addr[2:0]};
    end else if (par_std_hit) begin
      dif.dev = ildd_dev_parport;
      dif.idx = {1'b0, par_diff[2:0]};
    end else if (par_ext_hit) begin
      dif.dev = ildd_dev_parport;
      dif.idx = {`ILDD_IDX_PAR_EXT, par_diff[1:0]};
    end else if (ser1_hit) begin
      dif.dev = ildd_dev_serial1;
      dif.idx = {1'b0, dif.addr[2:0]};
    end else if (ser2_hit) begin
      dif.dev = ildd_dev_serial2;
      dif.idx = {1'b0, dif.addr[2:0]};
    end else if (dif.addr == `ILDD_RTC_ADDR0 || dif.addr == `ILDD_RTC_ADDR1) begin
      dif.dev = ildd_dev_rtc;
      dif.idx = `ILDD_IDX_RTC_ADDR;
    end else if (dif.addr == `ILDD_RTC_DATA0 || dif.addr == `ILDD_RTC_DATA1) begin
      dif.dev = ildd_dev_rtc;
      dif.idx = `ILDD_IDX_RTC_DATA;
    end else if (dif.addr == `ILDD_KBD_DATA) begin
      dif.dev = ildd_dev_kbd;
      dif.idx = `ILDD_IDX_KBD_DATA;
    end else if (dif.addr == `ILDD_KBD_CMD) begin
      dif.dev = ildd_dev_kbd;
      dif.idx = `ILDD_IDX_KBD_CMD;
    end
  end
endmodule
`default_nettype wire

/* File: design/ildd_decoder.sv */
// Top of the logical device I/O decoder: pin sync, cycle qualify, registered select
`timescale 1ns/100ps
`default_nettype none
`include "ildd_map.svh"
module ildd_decoder (
  // Clock, enable and reset
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic reset_n_i,
  // ISA bus pins
  input wire logic [15:0] isa_addr_i,
  input wire logic isa_ior_n_i,
  input wire logic isa_iow_n_i,
  input wire logic isa_aen_i,
  input wire logic isa_dack_n_i,
  // Configuration from the on-chip configuration logic
  input wire logic [15:0] fdc_base_i,
  input wire logic [15:0] par_base_i,
  input wire logic [15:0] ser1_base_i,
  input wire logic [15:0] ser2_base_i,
  input wire logic [3:0] win_en_i,
  input wire logic par_enh_mode_i,
  input wire ildd_pkg::ildd_dev_t dma_dev_i,
  // Zero wait indication, open-drain style
  output logic zero_wait_n_o,
  output logic zero_wait_oe_o,
  // Selection towards the logical devices
  output ildd_pkg::ildd_dev_t dev_sel_o,
  output logic [3:0] reg_idx_o,
  output logic rd_o,
  output logic wr_o,
  output logic dma_o,
  output logic access_pulse_o,
  output logic par_enh_ok_o
);
  import ildd_pkg::*;

  logic [19:0] sync1_reg;
  logic [19:0] sync2_reg;
  logic active_prev_reg;
  logic zero_wait_indication_reg;
  logic [15:0] sa;
  logic rd;
  logic wr;
  logic dack;
  logic aen;
  logic pio_cyc;
  logic dma_cyc;
  logic active;
  ildd_dev_t dev_next;
  logic [3:0] idx_next;
  logic zero_wait_indication_next;

  ildd_dec_if dif ();

  // Two-stage sync of every pin; stage one feeds stage two only
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 20'hf0000;
      sync2_reg <= 20'hf0000;
    end else if (ce_i) begin
      sync1_reg <= {isa_ior_n_i, isa_iow_n_i, ~isa_aen_i, isa_dack_n_i, isa_addr_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Synced pin views; aen is stored inverted so reset looks idle
  assign rd = ~sync2_reg[19];
  assign wr = ~sync2_reg[18];
  assign aen = ~sync2_reg[17];
  assign dack = ~sync2_reg[16];
  assign sa = sync2_reg[15:0];

  // A strobe with aen low and no dack is programmed I/O; a strobe under dack is DMA
  assign pio_cyc = (rd || wr) && !aen && !dack;
  assign dma_cyc = (rd || wr) && dack;
  assign active = pio_cyc || dma_cyc;

  // Address matcher
  assign dif.addr = sa;
  assign dif.fdc_base = fdc_base_i;
  assign dif.par_base = par_base_i;
  assign dif.ser1_base = ser1_base_i;
  assign dif.ser2_base = ser2_base_i;
  assign dif.win_en = win_en_i;
  assign dif.par_enh_mode = par_enh_mode_i;

  ildd_addr_decode u_match (
    .dif(dif)
  );

  // DMA ignores the address bus, so the target comes from configuration
  always_comb begin
    dev_next = ildd_dev_none;
    idx_next = `ILDD_IDX_NONE;
    if (dma_cyc) begin
      dev_next = dma_dev_i;
      if (dma_dev_i == ildd_dev_floppy) begin
        idx_next = `ILDD_IDX_FDC_FIFO;
      end else if (dma_dev_i == ildd_dev_parport) begin
        idx_next = `ILDD_IDX_PAR_FIFO;
      end
    end else if (pio_cyc) begin
      dev_next = dif.dev;
      idx_next = dif.idx;
    end
  end

  // Parallel port runs full length; the clock window stays standard too
  assign zero_wait_indication_next = dev_next == ildd_dev_floppy || dev_next == ildd_dev_serial1
                     || dev_next == ildd_dev_serial2 || dev_next == ildd_dev_kbd;

  // Registered selection
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dev_sel_o <= ildd_dev_none;
      reg_idx_o <= `ILDD_IDX_NONE;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      dma_o <= 1'b0;
    end else if (ce_i) begin
      dev_sel_o <= dev_next;
      reg_idx_o <= idx_next;
      rd_o <= active && rd;
      wr_o <= active && wr;
      dma_o <= dma_cyc;
    end
  end

  // One pulse per strobe that selects a device, so each access moves exactly one byte
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      active_prev_reg <= 1'b0;
      access_pulse_o <= 1'b0;
    end else if (ce_i) begin
      active_prev_reg <= active;
      access_pulse_o <= active && !active_prev_reg && dev_next != ildd_dev_none;
    end
  end

  // Zero wait drive and enhanced-mode status
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      zero_wait_indication_reg <= 1'b0;
      par_enh_ok_o <= 1'b0;
    end else if (ce_i) begin
      zero_wait_indication_reg <= zero_wait_indication_next;
      par_enh_ok_o <= dif.enh_ok;
    end
  end

  // Pin only ever pulls low; released otherwise
  assign zero_wait_n_o = 1'b0;
  assign zero_wait_oe_o = zero_wait_indication_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_par_std_cycle;
    dev_sel_o == ildd_dev_parport || dev_sel_o == ildd_dev_rtc |-> !zero_wait_oe_o;
  endproperty
  a_par_std_cycle: assert property (p_par_std_cycle)
    else $error("zero wait driven for a standard-length window");

  property p_zero_wait_indication_fast;
    ce_i && active && (dev_next == ildd_dev_floppy || dev_next == ildd_dev_kbd)
      |=> zero_wait_oe_o && !zero_wait_n_o;
  endproperty
  a_zero_wait_indication_fast: assert property (p_zero_wait_indication_fast)
    else $error("zero wait missing for a fast window");

  // Only the unlimited floppy window may lawfully cover a fixed address
  property p_rtc_index;
    ce_i && pio_cyc && (sa == 16'h0070 || sa == 16'h0074)
      && !(win_en_i[0] && sa[15:3] == fdc_base_i[15:3])
      |=> dev_sel_o == ildd_dev_rtc && reg_idx_o == 4'h0;
  endproperty
  a_rtc_index: assert property (p_rtc_index)
    else $error("clock index address not decoded");

  property p_kbd_cmd;
    ce_i && pio_cyc && sa == 16'h0064 && !(win_en_i[0] && sa[15:3] == fdc_base_i[15:3])
      |=> dev_sel_o == ildd_dev_kbd && reg_idx_o == 4'h1;
  endproperty
  a_kbd_cmd: assert property (p_kbd_cmd)
    else $error("keyboard command address not decoded");

  // DMA ignores the address bus, so only non-DMA cycles are judged here
  property p_full_compare;
    ce_i && !dma_cyc && sa[15:8] != 8'h00
      |=> dev_sel_o != ildd_dev_rtc && dev_sel_o != ildd_dev_kbd;
  endproperty
  a_full_compare: assert property (p_full_compare)
    else $error("fixed window hit with upper address bits set");

  property p_fdc_reloc;
    ce_i && pio_cyc && win_en_i[0] && sa[15:3] == fdc_base_i[15:3] && sa[2:0] == 3'h7
      |=> dev_sel_o == ildd_dev_floppy && reg_idx_o == 4'h7;
  endproperty
  a_fdc_reloc: assert property (p_fdc_reloc)
    else $error("floppy window offset 7 not decoded at base");

  // A frozen enable keeps the old flag, so only enabled edges are judged
  property p_enh_align;
    ce_i && par_base_i[2] |=> !par_enh_ok_o;
  endproperty
  a_enh_align: assert property (p_enh_align)
    else $error("enhanced mode flagged on a 4-byte base");

  property p_dma_fifo;
    ce_i && dma_cyc && dma_dev_i == ildd_dev_floppy
      |=> dma_o && dev_sel_o == ildd_dev_floppy && reg_idx_o == 4'h5;
  endproperty
  a_dma_fifo: assert property (p_dma_fifo)
    else $error("floppy DMA cycle not routed to data FIFO");

  property p_one_byte;
    ce_i && access_pulse_o |=> !access_pulse_o;
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("more than one access pulse for a strobe");

  property p_par_ext;
    ce_i && pio_cyc && dev_next == ildd_dev_parport && dif.idx == 4'ha
      |=> reg_idx_o == 4'ha && $past(sa) - {$past(par_base_i[15:2]), 2'b00} == 16'h0402;
  endproperty
  a_par_ext: assert property (p_par_ext)
    else $error("parallel extended control decode wrong");

  c_fdc_pio: cover property (ce_i && pio_cyc ##1 dev_sel_o == ildd_dev_floppy);
  c_par_ext: cover property (dev_sel_o == ildd_dev_parport && reg_idx_o == 4'ha);
  c_dma: cover property (dma_o && access_pulse_o);
  c_serial2: cover property (dev_sel_o == ildd_dev_serial2 && zero_wait_oe_o);
endmodule
`default_nettype wire

/* File: dv/ildd_host_model.sv */
// Behavioural ISA host that runs one byte access at a time
`timescale 1ns/100ps
`default_nettype none
module ildd_host_model (
  // Clock
  input wire logic core_clk_i,
  // ISA pins towards the decoder
  output logic [15:0] isa_addr_o,
  output logic isa_ior_n_o,
  output logic isa_iow_n_o,
  output logic isa_aen_o,
  output logic isa_dack_n_o
);
  // Idle bus at time zero
  initial begin
    isa_addr_o = 16'h0000;
    isa_ior_n_o = 1'b1;
    isa_iow_n_o = 1'b1;
    isa_aen_o = 1'b0;
    isa_dack_n_o = 1'b1;
  end
  // Address two cycles ahead of the strobe, then three edges for the answer
  task automatic start(input logic [15:0] a, input logic w, input logic ae, input logic dk_n);
    isa_addr_o = a;
    isa_aen_o = ae;
    isa_dack_n_o = dk_n;
    repeat (2) @(posedge core_clk_i);
    #1;
    isa_ior_n_o = w;
    isa_iow_n_o = ~w; // One strobe carries one byte
    repeat (3) @(posedge core_clk_i);
    #2;
  endtask
  // Release: address inverted so a stale value never looks held
  task automatic finish();
    @(posedge core_clk_i);
    #1;
    isa_ior_n_o = 1'b1;
    isa_iow_n_o = 1'b1;
    isa_addr_o = ~isa_addr_o;
    isa_aen_o = 1'b0;
    isa_dack_n_o = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/ildd_decoder_bench.sv */
// Self-checking bench for the logical device I/O decoder
`timescale 1ns/100ps
`default_nettype none
module ildd_decoder_bench;
  import ildd_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce = 1'b1;
  logic [15:0] addr, fdc_base, par_base, ser1_base, ser2_base;
  logic ior_n, iow_n, aen, dack_n, enh_mode, zw_n, zw_oe, rd, wr, dma, pulse, enh_ok;
  logic [3:0] win_en, reg_idx;
  ildd_dev_t dma_dev, dev_sel;
  logic [15:0] pick [5];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 core_clk_i = ~core_clk_i;

  ildd_decoder ildd_decoder_i (.core_clk_i(core_clk_i), .ce_i(ce), .reset_n_i(reset_n_i),
    .isa_addr_i(addr), .isa_ior_n_i(ior_n), .isa_iow_n_i(iow_n), .isa_aen_i(aen),
    .isa_dack_n_i(dack_n), .fdc_base_i(fdc_base), .par_base_i(par_base),
    .ser1_base_i(ser1_base), .ser2_base_i(ser2_base), .win_en_i(win_en),
    .par_enh_mode_i(enh_mode), .dma_dev_i(dma_dev), .zero_wait_n_o(zw_n),
    .zero_wait_oe_o(zw_oe), .dev_sel_o(dev_sel), .reg_idx_o(reg_idx), .rd_o(rd), .wr_o(wr),
    .dma_o(dma), .access_pulse_o(pulse), .par_enh_ok_o(enh_ok));
  ildd_host_model ildd_host_model_i (.core_clk_i(core_clk_i), .isa_addr_o(addr),
    .isa_ior_n_o(ior_n), .isa_iow_n_o(iow_n), .isa_aen_o(aen), .isa_dack_n_o(dack_n));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, about nine times the expected run
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("[FAIL] run length expected under 30000 seen more");
      test_done();
    end
  end

  function automatic logic par_ok();
    return win_en[1] && par_base >= 16'h0100 && par_base <= 16'h0ffc;
  endfunction
  function automatic logic ser_hit(input logic en, input logic [15:0] b, input logic [15:0] a);
    return en && b >= 16'h0100 && b <= 16'h0ff8 && a[15:3] == b[15:3];
  endfunction
  // Expected {zero wait, device, index}, checked in overlap priority order
  function automatic logic [7:0] expect_of(input logic [15:0] a);
    logic [15:0] po;
    po = a - par_base;
    if (win_en[0] && a[15:3] == fdc_base[15:3] && a[2:0] != 3'h6)
      return {1'b1, ildd_dev_floppy, 1'b0, a[2:0]};
    if (par_ok() && a[15:2] == par_base[15:2] && a[1:0] != 2'h3)
      return {1'b0, ildd_dev_parport, 2'h0, a[1:0]};
    if (par_ok() && enh_mode && par_base[2:0] == 3'h0 && a[15:3] == par_base[15:3])
      return {1'b0, ildd_dev_parport, 1'b0, a[2:0]};
    if (par_ok() && po >= 16'h0400 && po <= 16'h0402)
      return {1'b0, ildd_dev_parport, 2'h2, po[1:0]};
    if (ser_hit(win_en[2], ser1_base, a)) return {1'b1, ildd_dev_serial1, 1'b0, a[2:0]};
    if (ser_hit(win_en[3], ser2_base, a)) return {1'b1, ildd_dev_serial2, 1'b0, a[2:0]};
    if (a == 16'h0070 || a == 16'h0074) return {1'b0, ildd_dev_rtc, 4'h0};
    if (a == 16'h0071 || a == 16'h0076) return {1'b0, ildd_dev_rtc, 4'h1};
    if (a == 16'h0060 || a == 16'h0064) return {1'b1, ildd_dev_kbd, 2'h0, a[3:2]};
    return 8'h00;
  endfunction

  // One access through the host model, checked in the cycle the pulse stands
  task automatic acc(input logic [15:0] a, input logic w, input logic ae, input logic dk_n);
    logic [7:0] e;
    e = expect_of(a);
    if (ae)
      e = dk_n ? 8'h00 : {1'b0, dma_dev, dma_dev == ildd_dev_floppy ? 4'h5 :
                          dma_dev == ildd_dev_parport ? 4'h8 : 4'h0};
    ildd_host_model_i.start(a, w, ae, dk_n);
    chk("dev_sel", 16'(dev_sel), 16'(e[6:4]));
    chk("reg_idx", 16'(reg_idx), 16'(e[3:0]));
    chk("pulse", 16'(pulse), 16'(e[6:4] != 3'h0));
    chk("enh_ok", 16'(enh_ok), 16'(par_ok() && par_base[2:0] == 3'h0));
    if (!ae) chk("zero_wait", {14'h0, zw_oe, zw_n}, {14'h0, e[7], 1'b0});
    if (e[6:4] != 3'h0) chk("strobes", {13'h0, rd, wr, dma}, {13'h0, ~w, w, ae});
    ildd_host_model_i.finish();
    chk("idle", 16'(dev_sel), 16'h0000);
  endtask

  // Main sequence: fixed windows, relocated offsets, DMA, then random traffic
  initial begin
    void'($urandom(32'hc2afb919));
    fdc_base = 16'h03f0;
    par_base = 16'h0378;
    ser1_base = 16'h03f8;
    ser2_base = 16'h02f8;
    win_en = 4'hf;
    enh_mode = 1'b0;
    dma_dev = ildd_dev_none;
    repeat (16) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    // First pin change waits one cycle past the release
    @(posedge core_clk_i);
    #1;
    foreach (pick[i]) acc(16'h0060 + 16'(i * 4), i[0], 1'b0, 1'b1);
    foreach (pick[i]) acc(16'h0070 + 16'(i + i / 2), i[0], 1'b0, 1'b1);
    acc(16'h8070, 1'b0, 1'b0, 1'b1); // Upper bits must spoil the match
    acc(16'h0064, 1'b0, 1'b1, 1'b1); // Address owned by DMA, no acknowledge
    // Frozen enable: a whole strobe passes unseen and leaves no select behind
    ce = 1'b0;
    ildd_host_model_i.start(16'h0060, 1'b0, 1'b0, 1'b1);
    chk("frozen_dev", 16'(dev_sel), 16'h0000);
    chk("frozen_pulse", 16'(pulse), 16'h0000);
    ildd_host_model_i.finish();
    ce = 1'b1;
    $display("test fixed done");
    for (int m = 0; m < 3; m++) begin
      enh_mode = m[0] | m[1];
      par_base = m[1] ? 16'h0ffc : 16'h0378; // Top of range, 4-byte aligned only
      for (int i = 0; i < 8; i++) begin
        acc(fdc_base + 16'(i), i[0], 1'b0, 1'b1);
        acc(par_base + 16'(i), i[1], 1'b0, 1'b1);
        acc(par_base + 16'h0400 + 16'(i), i[0], 1'b0, 1'b1);
        acc(ser1_base + 16'(i), i[1], 1'b0, 1'b1);
        acc(ser2_base + 16'(i), i[0], 1'b0, 1'b1);
      end
    end
    $display("test offsets done");
    for (int d = 0; d < 7; d++) begin
      dma_dev = ildd_dev_t'(d);
      acc(16'($urandom), d[0], 1'b1, 1'b0);
    end
    $display("test dma done");
    // Random bases reach past both ends of the legal ranges
    repeat (200) begin
      win_en = 4'($urandom);
      enh_mode = 1'($urandom);
      fdc_base = {4'h0, 9'($urandom), 3'h0};
      par_base = {3'h0, 11'($urandom), 2'h0};
      ser1_base = {3'h0, 10'($urandom), 3'h0};
      ser2_base = ($urandom % 4 == 0) ? 16'h0ff8 : {3'h0, 10'($urandom), 3'h0};
      pick = '{fdc_base, par_base, ser1_base, ser2_base, par_base + 16'h0400};
      acc(pick[$urandom % 5] + 16'($urandom % 8), 1'($urandom), 1'b0, 1'b1);
    end
    $display("test random done");
    test_done();
  end
endmodule
`default_nettype wire
